//--- verilog/thd_monitor_pkg.sv
/*
  Constants, field layouts and types shared by the current distortion monitor.
  Assumes a single 25 MHz core clock and a spectral stage that refreshes every 5 ms.
*/
package thd_monitor_pkg;
  localparam int NUM_CH = 5;
  localparam int NUM_ELEM = 3;
  localparam int NUM_SRC = 7;
  localparam int LOG_DEPTH = 12;
  localparam int RATIO_W = 16;
  localparam int DELAY_W = 19;
  localparam logic [4:0] FUND_INDEX = 5'h01;
  localparam logic [4:0] HARM_FIRST = 5'h02;
  // Ratio in hundredths of percent: power scale 1e4, amplitude 1e8 before the root
  localparam logic [26:0] POWER_SCALE = 27'h000_2710;
  localparam logic [26:0] AMPL_SCALE = 27'h5F5_E100;
  localparam logic [6:0] RELEASE_PERCENT = 7'h61;
  localparam logic [6:0] PERCENT_FULL = 7'h64;
  localparam logic [15:0] THRESHOLD_DEFAULT = 16'h03E8;
  localparam int UPDATE_PERIOD_MS = 5;
  localparam int DELAY_DEFAULT_MS = 10000;
  localparam logic [DELAY_W-1:0] DELAY_DEFAULT = DELAY_W'(DELAY_DEFAULT_MS / UPDATE_PERIOD_MS);
  localparam logic [13:0] EVENT_MASK_RESET = 14'h3FFF;
  localparam int CTRL_METHOD_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_ENABLE_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0070;
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_THRESHOLD_BASE = 8'h04;
  localparam logic [7:0] REG_DELAY_BASE = 8'h10;
  localparam logic [7:0] REG_EVENT_MASK = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_DISTORTION_BASE = 8'h24;
  localparam logic [7:0] REG_COUNT_CLEAR = 8'h38;
  localparam logic [7:0] REG_COUNT_BASE = 8'h40;
  localparam logic [7:0] REG_LOG_SELECT = 8'h60;
  localparam logic [7:0] REG_LOG_TIME = 8'h64;
  localparam logic [7:0] REG_LOG_INFO = 8'h68;
  localparam logic [7:0] REG_LOG_PHASE_AB = 8'h6C;
  localparam logic [7:0] REG_LOG_PHASE_C = 8'h70;
  localparam int SRC_BLOCKED = 6;
  typedef enum logic [2:0] {MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED, MODE_OFF} mode_t;
  typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_ALARM, COND_BLOCKED} condition_t;
  typedef enum logic [2:0] {CALC_IDLE, CALC_SETUP, CALC_DIV, CALC_SQRT, CALC_STORE,
    CALC_EVAL} calc_state_t;
endpackage

//--- verilog/current_thd_monitor.sv
/*
  Current distortion monitor: spectrum accumulation, ratio arithmetic, three alarm
  elements, event serialiser, counters, twelve-entry log and Avalon-MM register slave.
  Assumes the spectral stage, blocking matrix, timestamp and group inputs share core_clk.
*/
`timescale 1ns/1ps
module current_thd_monitor
  import thd_monitor_pkg::*;
#(
  parameter int MAG_W = 16,
  parameter int CNT_W = 32
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic spectrum_valid,
  input wire logic [2:0] spectrum_channel,
  input wire logic [4:0] spectrum_harmonic,
  input wire logic [MAG_W-1:0] spectrum_magnitude,
  input wire logic measurement_update,
  input wire logic block_input,
  input wire logic [31:0] timestamp,
  input wire logic [2:0] active_group,
  output logic [NUM_ELEM-1:0] start_out,
  output logic [NUM_ELEM-1:0] alarm_out,
  output logic blocked_out,
  output logic [1:0] condition,
  output logic [2:0] function_mode_indication,
  output logic event_valid,
  output logic [2:0] event_source,
  output logic event_on,
  output logic [31:0] event_time
);
  localparam int DIV_W = 2 * MAG_W;
  localparam int SUM_W = DIV_W + 5;
  localparam int ROOT_W = DIV_W / 2;

  logic [31:0] ctrl, next_ctrl;
  logic [15:0] threshold [NUM_ELEM];
  logic [15:0] next_threshold [NUM_ELEM];
  logic [DELAY_W-1:0] delay_steps [NUM_ELEM];
  logic [DELAY_W-1:0] next_delay_steps [NUM_ELEM];
  logic [13:0] event_mask, next_event_mask;
  logic [3:0] log_select, next_log_select;
  logic served, next_served;
  logic [31:0] next_readdata;
  logic write_take;
  logic [NUM_SRC-1:0] count_clear;

  logic [DIV_W-1:0] mag_sq;
  logic [DIV_W-1:0] fund_acc [NUM_CH];
  logic [DIV_W-1:0] next_fund_acc [NUM_CH];
  logic [SUM_W-1:0] sum_acc [NUM_CH];
  logic [SUM_W-1:0] next_sum_acc [NUM_CH];

  calc_state_t state, next_state;
  logic [2:0] ch, next_ch;
  logic [4:0] bit_idx, next_bit_idx;
  logic [2*DIV_W-1:0] num, next_num, product;
  logic [DIV_W-1:0] rem, next_rem, quo, next_quo;
  logic [DIV_W:0] trial;
  logic [ROOT_W-1:0] root, next_root, root_try;
  logic [RATIO_W-1:0] ratio [NUM_CH];
  logic [RATIO_W-1:0] next_ratio [NUM_CH];
  logic [SUM_W-1:0] sum_snap [NUM_CH];
  logic [SUM_W-1:0] next_sum_snap [NUM_CH];
  logic [DIV_W-1:0] fund_snap [NUM_CH];
  logic [DIV_W-1:0] next_fund_snap [NUM_CH];
  logic block_sample, next_block_sample;
  logic power_mode;

  mode_t mode_eff;
  logic mode_off, mode_blocking;
  logic [NUM_ELEM-1:0] active, next_active, next_start, next_alarm;
  logic [NUM_ELEM-1:0] blocked_elem, next_blocked_elem, over_lvl, hold_lvl, picked;
  logic [DELAY_W-1:0] timer [NUM_ELEM];
  logic [DELAY_W-1:0] next_timer [NUM_ELEM];
  logic [DELAY_W-1:0] elapsed;
  logic [15:0] release_lvl [NUM_ELEM];
  logic [1:0] next_condition;

  logic [NUM_SRC-1:0] src_now, src_prev, pend_on, pend_off;
  logic [NUM_SRC-1:0] next_pend_on, next_pend_off, pick_mask;
  logic pick_any, pick_on;
  logic [2:0] pick_idx;
  logic next_event_valid, next_event_on;
  logic [2:0] next_event_source;
  logic [31:0] next_event_time;
  logic [CNT_W-1:0] counter [NUM_SRC];
  logic [CNT_W-1:0] next_counter [NUM_SRC];
  logic [31:0] log_time [LOG_DEPTH];
  logic [31:0] next_log_time [LOG_DEPTH];
  logic [2:0] log_src [LOG_DEPTH];
  logic [2:0] next_log_src [LOG_DEPTH];
  logic [2:0] log_group [LOG_DEPTH];
  logic [2:0] next_log_group [LOG_DEPTH];
  logic [RATIO_W-1:0] log_ratio [LOG_DEPTH][3];
  logic [RATIO_W-1:0] next_log_ratio [LOG_DEPTH][3];
  logic [3:0] log_wr, next_log_wr, log_count, next_log_count;
  logic [4:0] log_rd_raw;
  logic [3:0] log_rd;

  assign power_mode = ctrl[CTRL_METHOD_BIT];
  assign mag_sq = DIV_W'(spectrum_magnitude * spectrum_magnitude);

  // Mode decode; an illegal code behaves as Off
  always_comb
  begin
    unique case (ctrl[CTRL_MODE_LSB +: 3])
      3'h0: mode_eff = MODE_ON;
      3'h1: mode_eff = MODE_BLOCKED;
      3'h2: mode_eff = MODE_TEST;
      3'h3: mode_eff = MODE_TEST_BLOCKED;
      default: mode_eff = MODE_OFF;
    endcase
    mode_off = (mode_eff == MODE_OFF);
    mode_blocking = (mode_eff == MODE_BLOCKED) || (mode_eff == MODE_TEST_BLOCKED);
  end

  // Bus slave: one wait cycle per access, answer at the second edge
  assign avs_waitrequest = (avs_read || avs_write) && !served;
  assign write_take = avs_write && served;
  assign count_clear = (write_take && avs_address == REG_COUNT_CLEAR) ?
    avs_writedata[NUM_SRC-1:0] : '0;

  assign log_rd_raw = 5'(log_wr) + 5'(LOG_DEPTH - 1) - 5'(log_select);
  assign log_rd = (log_rd_raw >= 5'(LOG_DEPTH)) ? 4'(log_rd_raw - 5'(LOG_DEPTH)) : 4'(log_rd_raw);

  always_comb
  begin
    next_ctrl = ctrl;
    next_threshold = threshold;
    next_delay_steps = delay_steps;
    next_event_mask = event_mask;
    next_log_select = log_select;
    next_served = (avs_read || avs_write) && !served;
    next_readdata = avs_readdata;
    if (write_take)
    begin
      if (avs_address == REG_CONTROL)
        next_ctrl = {25'h000_0000, avs_writedata[6:0]};
      if (avs_address == REG_EVENT_MASK)
        next_event_mask = avs_writedata[13:0];
      if (avs_address == REG_LOG_SELECT && avs_writedata[3:0] < 4'(LOG_DEPTH))
        next_log_select = avs_writedata[3:0];
      for (int e = 0; e < NUM_ELEM; e++)
      begin
        // Settings take effect at the next measurement update, no restart
        if (avs_address == REG_THRESHOLD_BASE + 8'(4 * e))
          next_threshold[e] = avs_writedata[15:0];
        if (avs_address == REG_DELAY_BASE + 8'(4 * e))
          next_delay_steps[e] = avs_writedata[DELAY_W-1:0];
      end
    end
    if (avs_read && !served)
    begin
      next_readdata = '0;
      if (avs_address == REG_CONTROL)
        next_readdata = ctrl;
      if (avs_address == REG_EVENT_MASK)
        next_readdata = 32'(event_mask);
      if (avs_address == REG_STATUS)
        next_readdata = {16'h0000, log_count, blocked_out, alarm_out, start_out,
          function_mode_indication, condition};
      if (avs_address == REG_LOG_SELECT)
        next_readdata = 32'(log_select);
      if (avs_address == REG_LOG_TIME)
        next_readdata = log_time[log_rd];
      if (avs_address == REG_LOG_INFO)
        next_readdata = {26'h000_0000, log_group[log_rd], log_src[log_rd]};
      if (avs_address == REG_LOG_PHASE_AB)
        next_readdata = {log_ratio[log_rd][1], log_ratio[log_rd][0]};
      if (avs_address == REG_LOG_PHASE_C)
        next_readdata = 32'(log_ratio[log_rd][2]);
      for (int e = 0; e < NUM_ELEM; e++)
      begin
        if (avs_address == REG_THRESHOLD_BASE + 8'(4 * e))
          next_readdata = 32'(threshold[e]);
        if (avs_address == REG_DELAY_BASE + 8'(4 * e))
          next_readdata = 32'(delay_steps[e]);
      end
      for (int c = 0; c < NUM_CH; c++)
        if (avs_address == REG_DISTORTION_BASE + 8'(4 * c))
          next_readdata = 32'(ratio[c]);
      for (int s = 0; s < NUM_SRC; s++)
        if (avs_address == REG_COUNT_BASE + 8'(4 * s))
          next_readdata = 32'(counter[s]);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ctrl <= CTRL_RESET;
      threshold <= '{default: THRESHOLD_DEFAULT};
      delay_steps <= '{default: DELAY_DEFAULT};
      event_mask <= EVENT_MASK_RESET;
      log_select <= '0;
      served <= 1'b0;
      avs_readdata <= '0;
    end
    else
    begin
      ctrl <= next_ctrl;
      threshold <= next_threshold;
      delay_steps <= next_delay_steps;
      event_mask <= next_event_mask;
      log_select <= next_log_select;
      served <= next_served;
      avs_readdata <= next_readdata;
    end
  end

  // Spectrum accumulation; an update closes the frame and starts the next
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      next_fund_acc[c] = measurement_update ? '0 : fund_acc[c];
      next_sum_acc[c] = measurement_update ? '0 : sum_acc[c];
      if (spectrum_valid && spectrum_channel == 3'(c))
      begin
        if (spectrum_harmonic == FUND_INDEX)
          next_fund_acc[c] = mag_sq;
        else if (spectrum_harmonic >= HARM_FIRST)
          next_sum_acc[c] = next_sum_acc[c] + SUM_W'(mag_sq);
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      fund_acc <= '{default: '0};
      sum_acc <= '{default: '0};
    end
    else
    begin
      fund_acc <= next_fund_acc;
      sum_acc <= next_sum_acc;
    end
  end

  // Ratio engine: serial divide, then a bitwise root for amplitude ratio
  assign product = (2*DIV_W)'(sum_snap[ch]) * (2*DIV_W)'(power_mode ? POWER_SCALE : AMPL_SCALE);
  assign trial = {rem, num[bit_idx]};
  assign root_try = root | (ROOT_W'(1) << bit_idx[3:0]);

  always_comb
  begin
    next_state = state;
    next_ch = ch;
    next_bit_idx = bit_idx;
    next_num = num;
    next_rem = rem;
    next_quo = quo;
    next_root = root;
    next_ratio = ratio;
    next_sum_snap = sum_snap;
    next_fund_snap = fund_snap;
    next_block_sample = block_sample;
    unique case (state)
      CALC_IDLE:
        if (measurement_update)
        begin
          next_sum_snap = sum_acc;
          next_fund_snap = fund_acc;
          next_block_sample = block_input;
          next_ch = '0;
          next_state = CALC_SETUP;
        end
      CALC_SETUP:
      begin
        next_num = product;
        next_quo = '0;
        next_root = '0;
        next_bit_idx = 5'(DIV_W - 1);
        // Overflow or missing fundamental saturates the quotient
        if (product[2*DIV_W-1:DIV_W] >= fund_snap[ch])
        begin
          next_quo = '1;
          next_bit_idx = 5'(ROOT_W - 1);
          next_state = power_mode ? CALC_STORE : CALC_SQRT;
        end
        else
        begin
          next_rem = product[2*DIV_W-1:DIV_W];
          next_state = CALC_DIV;
        end
      end
      CALC_DIV:
      begin
        next_rem = trial[DIV_W-1:0];
        if (trial >= {1'b0, fund_snap[ch]})
        begin
          next_rem = DIV_W'(trial - {1'b0, fund_snap[ch]});
          next_quo[bit_idx] = 1'b1;
        end
        next_bit_idx = bit_idx - 5'h01;
        if (bit_idx == '0)
        begin
          next_bit_idx = 5'(ROOT_W - 1);
          next_state = power_mode ? CALC_STORE : CALC_SQRT;
        end
      end
      CALC_SQRT:
      begin
        if ((2*ROOT_W)'(root_try * root_try) <= quo)
          next_root = root_try;
        next_bit_idx = bit_idx - 5'h01;
        if (bit_idx == '0)
          next_state = CALC_STORE;
      end
      CALC_STORE:
      begin
        if (!power_mode)
          next_ratio[ch] = RATIO_W'(root);
        else if (quo[DIV_W-1:RATIO_W] != '0)
          next_ratio[ch] = '1;
        else
          next_ratio[ch] = quo[RATIO_W-1:0];
        next_ch = ch + 3'h1;
        if (ch == 3'(NUM_CH - 1))
          next_state = CALC_EVAL;
        else
          next_state = CALC_SETUP;
      end
      CALC_EVAL:
        next_state = CALC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state <= CALC_IDLE;
      ch <= '0;
      bit_idx <= '0;
      num <= '0;
      rem <= '0;
      quo <= '0;
      root <= '0;
      ratio <= '{default: '0};
      sum_snap <= '{default: '0};
      fund_snap <= '{default: '0};
      block_sample <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ch <= next_ch;
      bit_idx <= next_bit_idx;
      num <= next_num;
      rem <= next_rem;
      quo <= next_quo;
      root <= next_root;
      ratio <= next_ratio;
      sum_snap <= next_sum_snap;
      fund_snap <= next_fund_snap;
      block_sample <= next_block_sample;
    end
  end

  // Alarm elements, evaluated once per update
  always_comb
  begin
    next_active = active;
    next_start = start_out;
    next_alarm = alarm_out;
    next_blocked_elem = blocked_elem;
    next_timer = timer;
    over_lvl = '0;
    hold_lvl = '0;
    picked = '0;
    elapsed = '0;
    for (int e = 0; e < NUM_ELEM; e++)
      release_lvl[e] = 16'((23'(threshold[e]) * 23'(RELEASE_PERCENT)) / 23'(PERCENT_FULL));
    for (int c = 0; c < NUM_CH; c++)
    begin
      // Channels 0-2 share the phase element and its single threshold
      if (c < 3)
      begin
        over_lvl[0] = over_lvl[0] | (ratio[c] > threshold[0]);
        hold_lvl[0] = hold_lvl[0] | (ratio[c] >= release_lvl[0]);
      end
      else
      begin
        over_lvl[c-2] = ratio[c] > threshold[c-2];
        hold_lvl[c-2] = ratio[c] >= release_lvl[c-2];
      end
    end
    for (int e = 0; e < NUM_ELEM; e++)
    begin
      picked[e] = ctrl[CTRL_ENABLE_LSB + e] && !mode_off &&
        (active[e] ? hold_lvl[e] : over_lvl[e]);
      elapsed = start_out[e] ? timer[e] + DELAY_W'(1) : '0;
      if (state == CALC_EVAL)
      begin
        next_active[e] = picked[e];
        if (!picked[e])
        begin
          next_start[e] = 1'b0;
          next_alarm[e] = 1'b0;
          next_blocked_elem[e] = 1'b0;
          next_timer[e] = '0;
        end
        else if (block_sample || mode_blocking)
        begin
          next_blocked_elem[e] = 1'b1;
          next_start[e] = 1'b0;
          next_alarm[e] = 1'b0;
          next_timer[e] = '0;
        end
        else
        begin
          next_blocked_elem[e] = 1'b0;
          next_start[e] = 1'b1;
          if (elapsed >= delay_steps[e])
          begin
            next_alarm[e] = 1'b1;
            next_timer[e] = delay_steps[e];
          end
          else
            next_timer[e] = elapsed;
        end
      end
    end
    if (|next_blocked_elem)
      next_condition = COND_BLOCKED;
    else if (|next_alarm)
      next_condition = COND_ALARM;
    else if (|next_start)
      next_condition = COND_START;
    else
      next_condition = COND_NORMAL;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      active <= '0;
      start_out <= '0;
      alarm_out <= '0;
      blocked_elem <= '0;
      blocked_out <= 1'b0;
      timer <= '{default: '0};
      condition <= COND_NORMAL;
      function_mode_indication <= MODE_ON;
    end
    else
    begin
      active <= next_active;
      start_out <= next_start;
      alarm_out <= next_alarm;
      blocked_elem <= next_blocked_elem;
      blocked_out <= |next_blocked_elem;
      timer <= next_timer;
      condition <= next_condition;
      function_mode_indication <= mode_eff;
    end
  end

  // Event serialiser: one event per cycle, ON before OFF, lowest source first
  assign src_now = {blocked_out, alarm_out, start_out};

  always_comb
  begin
    pick_any = 1'b0;
    pick_on = 1'b0;
    pick_idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
      if (pend_off[i])
      begin
        pick_any = 1'b1;
        pick_idx = 3'(i);
      end
    for (int i = NUM_SRC - 1; i >= 0; i--)
      if (pend_on[i])
      begin
        pick_any = 1'b1;
        pick_on = 1'b1;
        pick_idx = 3'(i);
      end
    pick_mask = pick_any ? (NUM_SRC'(1) << pick_idx) : '0;
    // A new edge in the cycle its pending bit is taken is kept
    next_pend_on = (pend_on & ~(pick_on ? pick_mask : '0)) | (src_now & ~src_prev);
    next_pend_off = (pend_off & ~(pick_on ? '0 : pick_mask)) | (~src_now & src_prev);
    next_event_valid = pick_any && event_mask[{pick_idx, !pick_on}];
    next_event_source = pick_idx;
    next_event_on = pick_on;
    next_event_time = timestamp;
    next_log_time = log_time;
    next_log_src = log_src;
    next_log_group = log_group;
    next_log_ratio = log_ratio;
    next_log_wr = log_wr;
    next_log_count = log_count;
    for (int s = 0; s < NUM_SRC; s++)
    begin
      next_counter[s] = count_clear[s] ? '0 : counter[s];
      if (pick_on && pick_idx == 3'(s))
        next_counter[s] = next_counter[s] + CNT_W'(1);
    end
    if (pick_any && pick_on)
    begin
      next_log_time[log_wr] = timestamp;
      next_log_src[log_wr] = pick_idx;
      next_log_group[log_wr] = active_group;
      for (int c = 0; c < 3; c++)
        next_log_ratio[log_wr][c] = ratio[c];
      next_log_wr = (log_wr == 4'(LOG_DEPTH - 1)) ? '0 : log_wr + 4'h1;
      if (log_count != 4'(LOG_DEPTH))
        next_log_count = log_count + 4'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      src_prev <= '0;
      pend_on <= '0;
      pend_off <= '0;
      event_valid <= 1'b0;
      event_source <= '0;
      event_on <= 1'b0;
      event_time <= '0;
      counter <= '{default: '0};
      log_time <= '{default: '0};
      log_src <= '{default: '0};
      log_group <= '{default: '0};
      log_ratio <= '{default: '{default: '0}};
      log_wr <= '0;
      log_count <= '0;
    end
    else
    begin
      src_prev <= src_now;
      pend_on <= next_pend_on;
      pend_off <= next_pend_off;
      event_valid <= next_event_valid;
      event_source <= next_event_source;
      event_on <= next_event_on;
      event_time <= next_event_time;
      counter <= next_counter;
      log_time <= next_log_time;
      log_src <= next_log_src;
      log_group <= next_log_group;
      log_ratio <= next_log_ratio;
      log_wr <= next_log_wr;
      log_count <= next_log_count;
    end
  end
endmodule

//--- test/thd_checker.sv
/* Checker for the distortion monitor: bus wait states and output relations.
   Assumes it is bound to the monitor top and sees only its ports. */
`timescale 1ns/1ps
module thd_checker
  import thd_monitor_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic measurement_update,
  input wire logic [2:0] start_out,
  input wire logic [2:0] alarm_out,
  input wire logic blocked_out,
  input wire logic [1:0] condition,
  input wire logic event_valid
);
  logic [9:0] since_upd;
  logic [9:0] next_since_upd;
  // Saturates so a long quiet spell never wraps into the active window
  always_comb
  begin
    next_since_upd = measurement_update ? 10'h000 : since_upd + 10'(since_upd != 10'h3FF);
  end
  always_ff @(posedge core_clk)
  begin
    since_upd <= resetn ? next_since_upd : 10'h3FF;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  a_read_waits_first: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered without wait cycle");
  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
  a_alarm_has_start: assert property ((alarm_out & ~start_out) == 3'h0)
    else $error("alarm without start");
  a_blocked_clears: assert property (blocked_out |-> start_out == 3'h0 && alarm_out == 3'h0)
    else $error("start or alarm while blocked");
  a_cond_blocked: assert property (blocked_out |-> condition == COND_BLOCKED)
    else $error("condition not blocked");
  a_cond_alarm: assert property (!blocked_out && alarm_out != 3'h0 |-> condition == COND_ALARM)
    else $error("condition not alarm");
  a_cond_normal: assert property (!blocked_out && start_out == 3'h0 |-> condition == COND_NORMAL)
    else $error("condition not normal");
  a_start_on_update: assert property ($changed(start_out) |-> since_upd <= 10'h12C)
    else $error("start moved outside an evaluation");
  a_event_on_update: assert property (event_valid |-> since_upd <= 10'h12C)
    else $error("event outside an evaluation");
  cover property (blocked_out);
  cover property (alarm_out[0]);
  cover property ($rose(start_out[0]));
endmodule

//--- test/spectrum_source.sv
/* Model of the spectral stage and blocking matrix feeding the monitor.
   Assumes frame() is called just after a rising edge of core_clk. */
`timescale 1ns/1ps
module spectrum_source
(
  input wire logic core_clk,
  output logic spectrum_valid = 1'b0,
  output logic [2:0] spectrum_channel = 3'h0,
  output logic [4:0] spectrum_harmonic = 5'h00,
  output logic [15:0] spectrum_magnitude = 16'h0000,
  output logic measurement_update = 1'b0,
  output logic block_input = 1'b0
);
  task automatic frame(input logic [15:0] fund, input logic [15:0] harm, input logic blk);
    block_input <= blk;
    for (int c = 0; c < 5; c++)
      for (int k = 0; k < 32; k++)
      begin
        spectrum_valid <= 1'b1;
        spectrum_channel <= 3'(c);
        spectrum_harmonic <= 5'(k);
        spectrum_magnitude <= k == 1 ? fund : (k == 2 ? harm : 16'h0000);
        @(posedge core_clk);
      end
    spectrum_valid <= 1'b0;
    // Idle lines must not keep showing the last sample
    spectrum_magnitude <= ~spectrum_magnitude;
    measurement_update <= 1'b1;
    @(posedge core_clk);
    measurement_update <= 1'b0;
    repeat (300) @(posedge core_clk);
  endtask
endmodule

//--- test/tb.sv
/* Self-checking bench: reads queue their expectation, a monitor compares.
   Assumes the package, monitor, checker and spectrum model compile first. */
`timescale 1ns/1ps
module tb
  import thd_monitor_pkg::*;
;
  logic core_clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, timestamp = 32'h0000_0000, avs_readdata, event_time;
  logic [2:0] active_group = 3'h0, start_out, alarm_out, function_mode_indication, event_source;
  logic avs_waitrequest, spectrum_valid, measurement_update, block_input, blocked_out;
  logic event_valid, event_on;
  logic [2:0] spectrum_channel;
  logic [4:0] spectrum_harmonic;
  logic [15:0] spectrum_magnitude;
  logic [1:0] condition;
  logic [31:0] exp_q[$], exp_ev[$], prev_ts;
  int n_fail = 0, checks_done = 0;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    prev_ts <= timestamp;
    timestamp <= $urandom;
  end
  current_thd_monitor dut (.core_clk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .spectrum_valid, .spectrum_channel,
    .spectrum_harmonic, .spectrum_magnitude, .measurement_update, .block_input, .timestamp,
    .active_group, .start_out, .alarm_out, .blocked_out, .condition, .function_mode_indication,
    .event_valid, .event_source, .event_on, .event_time);
  spectrum_source src (.core_clk, .spectrum_valid, .spectrum_channel, .spectrum_harmonic,
    .spectrum_magnitude, .measurement_update, .block_input);
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      n_fail++;
      $display("BAD %0t read %h expected %h", $time, seen, want);
    end
  endtask
  always @(posedge core_clk)
    if (avs_read && avs_waitrequest === 1'b0)
      check(avs_readdata, exp_q.pop_front());
  // Events carry the timestamp of the cycle before they appear
  always @(posedge core_clk)
    if (event_valid === 1'b1)
    begin
      check(32'({event_on, event_source}), exp_ev.pop_front());
      check(event_time, prev_ts);
    end
  // Reads note their expectation; writes pass data only
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w)
      exp_q.push_back(d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #400_000;
    n_fail++;
    final_report();
  end
  initial
  begin
    void'($urandom(32'haa30_9ad2));
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    active_group <= 3'($urandom);
    @(posedge core_clk);
    bus(0, REG_CONTROL, CTRL_RESET);
    bus(0, REG_THRESHOLD_BASE, 32'(THRESHOLD_DEFAULT));
    bus(0, REG_DELAY_BASE, 32'(DELAY_DEFAULT));
    bus(0, REG_EVENT_MASK, 32'(EVENT_MASK_RESET));
    bus(0, 8'hFC, 32'h0000_0000);
    for (int m = 0; m < 5; m++)
    begin
      bus(1, REG_CONTROL, CTRL_RESET | 32'(m << CTRL_MODE_LSB));
      bus(0, REG_STATUS, 32'(m << 2));
    end
    bus(1, REG_CONTROL, 32'h0000_0030);
    $display("reset and mode tests done");
    bus(1, REG_DELAY_BASE, 32'h0000_0000);
    exp_ev = {exp_ev, 32'h0000_0008, 32'h0000_0009, 32'h0000_000B};
    src.frame(16'h0064, 16'h0014, 1'b0);
    bus(0, REG_DISTORTION_BASE, 32'h0000_07D0);
    bus(0, REG_DISTORTION_BASE + 8'h10, 32'h0000_07D0);
    bus(0, REG_STATUS, 32'h0000_3162);
    bus(0, REG_COUNT_BASE + 8'h0C, 32'h0000_0001);
    bus(0, REG_LOG_INFO, 32'({active_group, 3'h3}));
    bus(0, REG_LOG_PHASE_AB, 32'h07D0_07D0);
    $display("amplitude test done");
    bus(1, REG_THRESHOLD_BASE, 32'h0000_019A);
    bus(1, REG_CONTROL, CTRL_RESET | 32'h0000_0001);
    exp_ev = {exp_ev, 32'h0000_0001};
    src.frame(16'h0064, 16'h0014, 1'b0);
    bus(0, REG_DISTORTION_BASE, 32'h0000_0190);
    bus(0, REG_STATUS, 32'h0000_3122);
    exp_ev = {exp_ev, 32'h0000_0000, 32'h0000_0003};
    src.frame(16'h0064, 16'h0013, 1'b0);
    bus(0, REG_STATUS, 32'h0000_3000);
    $display("power and release test done");
    bus(1, REG_CONTROL, CTRL_RESET);
    exp_ev = {exp_ev, 32'h0000_000E};
    src.frame(16'h0064, 16'h0014, 1'b1);
    bus(0, REG_STATUS, 32'h0000_4803);
    bus(0, REG_COUNT_BASE + 8'h18, 32'h0000_0001);
    bus(1, REG_COUNT_CLEAR, 32'h0000_0040);
    bus(0, REG_COUNT_BASE + 8'h18, 32'h0000_0000);
    check(32'(exp_ev.size()), 32'h0000_0000);
    $display("blocking test done");
    final_report();
  end
endmodule
bind current_thd_monitor thd_checker chk (.core_clk, .resetn, .avs_read, .avs_write,
  .avs_waitrequest, .measurement_update, .start_out, .alarm_out, .blocked_out, .condition,
  .event_valid);
